// ---- common/psac_defs.vh ----
/*
 timing and key constants for the host controller of the asynchronous
 pseudo-static ram port; assumes a 40 MHz system clock (25 ns period).
*/
`ifndef PSAC_DEFS_VH
`define PSAC_DEFS_VH

// clock period in picoseconds
`define PSAC_CLK_PS 25000
// times in their printed units
`define PSAC_T_RC_NS 70
`define PSAC_T_WP_NS 45
`define PSAC_T_WR_NS 10
`define PSAC_T_CP_NS 12
`define PSAC_T_CHOX_NS 10
`define PSAC_T_C2LP_NS 70
`define PSAC_T_EP_NS 70
`define PSAC_T_EPS_NS 70
`define PSAC_T_EPH_NS 70
`define PSAC_T_EAS_NS 15
`define PSAC_T_AA_NS 65
`define PSAC_T_C2LH_US 50
`define PSAC_T_CHH_US 350
`define PSAC_T_CHHN_US 1
// least times rounded up to whole cycles, never below one
`define PSAC_CYC_NS(t) ((((t) * 1000) + `PSAC_CLK_PS - 1) / `PSAC_CLK_PS)
`define PSAC_CYC_US(t) ((((t) * 1000000) + `PSAC_CLK_PS - 1) / `PSAC_CLK_PS)
`define PSAC_MIN1(c) (((c) < 1) ? 1 : (c))

// power-down key: address bits 16 and 17 select the mode
`define PSAC_KEY_LO_BIT 16
`define PSAC_KEY_HI_BIT 17
`define PSAC_MODE_NAP 2'h0
`define PSAC_MODE_PARTIAL 2'h1
`define PSAC_MODE_SLEEP 2'h3

`endif

// ---- logic/psac_host.v ----
/*
 host controller driving an asynchronous pseudo-static ram port with
 separate strobes: power-up sequence, reads, writes, power-down program,
 power-down entry and exit. assumes a single 40 MHz clock, synchronous
 active-high reset taken as the moment supply became valid, and that the
 memory has no clock of its own.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psac_defs.vh"

module psac_host #(
    parameter ADDR_W = 22,
    parameter DATA_W = 16,
    parameter CNT_W = 24,
    parameter [CNT_W-1:0] PWRUP_LOW_CYC = `PSAC_MIN1(`PSAC_CYC_US(`PSAC_T_C2LH_US)),
    parameter [CNT_W-1:0] SLEEP_EXIT_CYC = `PSAC_MIN1(`PSAC_CYC_US(`PSAC_T_CHH_US)),
    parameter [CNT_W-1:0] OTHER_EXIT_CYC = `PSAC_MIN1(`PSAC_CYC_US(`PSAC_T_CHHN_US))
) (
    input wire clk,
    input wire rst,
    // user side
    input wire req_valid,
    input wire req_write,
    input wire [ADDR_W-1:0] req_addr,
    input wire [DATA_W-1:0] req_wdata,
    input wire [1:0] req_be,
    output reg req_ready,
    output reg rsp_valid,
    output reg [DATA_W-1:0] rsp_rdata,
    input wire pd_enter,
    input wire pd_exit,
    input wire pgm_req,
    input wire [1:0] pgm_mode,
    input wire pgm_top,
    output reg pd_active,
    output reg [1:0] pd_mode,
    output reg init_done,
    // memory side
    output reg [ADDR_W-1:0] mem_addr,
    input wire [DATA_W-1:0] mem_dq_in,
    output reg [DATA_W-1:0] mem_dq_out,
    output reg mem_dq_oe_n,
    output reg chip_select_n,
    output reg output_enable_n,
    output reg write_enable_n,
    output reg lower_byte_enable_n,
    output reg upper_byte_enable_n,
    output reg power_down_ctrl,
    output reg power_program_strobe_n
);

    // cycle counts derived from the printed minimums
    localparam [CNT_W-1:0] RC_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_RC_NS));
    localparam [CNT_W-1:0] AA_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_AA_NS)) + 1;
    localparam [CNT_W-1:0] WP_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_WP_NS));
    localparam [CNT_W-1:0] WR_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_WR_NS));
    localparam [CNT_W-1:0] CP_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_CP_NS));
    localparam [CNT_W-1:0] CHOX_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_CHOX_NS));
    localparam [CNT_W-1:0] C2LP_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_C2LP_NS));
    localparam [CNT_W-1:0] EP_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_EP_NS));
    localparam [CNT_W-1:0] EPS_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_EPS_NS));
    localparam [CNT_W-1:0] EPH_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_EPH_NS));
    localparam [CNT_W-1:0] EAS_CYC = `PSAC_MIN1(`PSAC_CYC_NS(`PSAC_T_EAS_NS));
    // write cycle: pulse plus recovery, never under the write cycle time
    localparam [CNT_W-1:0] WC_SUM = WP_CYC + WR_CYC;
    localparam [CNT_W-1:0] WREC_CYC = (WC_SUM < RC_CYC) ? (RC_CYC - WP_CYC) : WR_CYC;

    // one-hot states
    localparam [11:0] S_PU_LOW = 12'h001;
    localparam [11:0] S_PU_HOLD = 12'h002;
    localparam [11:0] S_IDLE = 12'h004;
    localparam [11:0] S_RD = 12'h008;
    localparam [11:0] S_WR_PULSE = 12'h010;
    localparam [11:0] S_WR_REC = 12'h020;
    localparam [11:0] S_GAP = 12'h040;
    localparam [11:0] S_PG_SET = 12'h080;
    localparam [11:0] S_PG_PULSE = 12'h100;
    localparam [11:0] S_PG_HOLD = 12'h200;
    localparam [11:0] S_PD_LOW = 12'h400;
    localparam [11:0] S_PD_ON = 12'h800;

    reg [11:0] state_q;
    reg [CNT_W-1:0] cnt_q;
    reg pgm_used_q;
    // read data pipeline; the pins are not on this clock
    reg [DATA_W-1:0] dq_s1_q;
    reg [DATA_W-1:0] dq_s2_q;

    // key address from the requested power-down mode and half
    function [ADDR_W-1:0] key_addr;
        input [1:0] mode;
        input top;
        reg [ADDR_W-1:0] a;
        begin
            a = {ADDR_W{1'b0}};
            a[`PSAC_KEY_LO_BIT] = mode[0];
            a[`PSAC_KEY_HI_BIT] = mode[1];
            if (mode == `PSAC_MODE_PARTIAL) begin
                a[ADDR_W-1:19] = {(ADDR_W-19){top}};
            end
            key_addr = a;
        end
    endfunction

    // read data passes two flip-flops before capture
    always @(posedge clk) begin
        dq_s1_q <= mem_dq_in;
        dq_s2_q <= dq_s1_q;
    end

    // main sequencer
    always @(posedge clk) begin
        if (rst) begin
            state_q <= S_PU_LOW;
            cnt_q <= {CNT_W{1'b0}};
            pgm_used_q <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= {DATA_W{1'b0}};
            pd_active <= 1'b0;
            pd_mode <= `PSAC_MODE_SLEEP;
            init_done <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_dq_out <= {DATA_W{1'b0}};
            mem_dq_oe_n <= 1'b1;
            chip_select_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            power_down_ctrl <= 1'b0;
            power_program_strobe_n <= 1'b1;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            cnt_q <= cnt_q + 1'b1;
            case (state_q)
                // control held low after supply valid, select high
                S_PU_LOW: begin
                    if (cnt_q >= PWRUP_LOW_CYC - 1'b1) begin
                        power_down_ctrl <= 1'b1;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= S_PU_HOLD;
                    end
                end
                // select high after control rises
                S_PU_HOLD: begin
                    if (cnt_q >= SLEEP_EXIT_CYC - 1'b1) begin
                        init_done <= 1'b1;
                        pd_active <= 1'b0;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= S_GAP;
                    end
                end
                // accept one command when idle
                S_IDLE: begin
                    cnt_q <= {CNT_W{1'b0}};
                    if (pd_enter) begin
                        power_down_ctrl <= 1'b0;
                        state_q <= S_PD_LOW;
                    end else if (pgm_req && !pgm_used_q) begin
                        mem_addr <= key_addr(pgm_mode, pgm_top);
                        state_q <= S_PG_SET;
                    end else if (req_valid && req_be != 2'h0) begin
                        req_ready <= 1'b1;
                        pgm_used_q <= 1'b1;
                        mem_addr <= req_addr;
                        lower_byte_enable_n <= ~req_be[0];
                        upper_byte_enable_n <= ~req_be[1];
                        chip_select_n <= 1'b0;
                        if (req_write) begin
                            // select and write strobe fall together with
                            // output enable high: no read is begun
                            write_enable_n <= 1'b0;
                            mem_dq_out <= req_wdata;
                            mem_dq_oe_n <= 1'b0;
                            state_q <= S_WR_PULSE;
                        end else begin
                            output_enable_n <= 1'b0;
                            state_q <= S_RD;
                        end
                    end
                end
                // full read cycle, data captured after access plus sync
                S_RD: begin
                    if (cnt_q >= RC_CYC + 2'd2 - 1'b1 &&
                        cnt_q >= AA_CYC + 2'd2 - 1'b1) begin
                        rsp_rdata <= dq_s2_q;
                        rsp_valid <= 1'b1;
                        chip_select_n <= 1'b1;
                        output_enable_n <= 1'b1;
                        lower_byte_enable_n <= 1'b1;
                        upper_byte_enable_n <= 1'b1;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= S_GAP;
                    end
                end
                // write pulse, select and strobe low together
                S_WR_PULSE: begin
                    if (cnt_q >= WP_CYC - 1'b1) begin
                        write_enable_n <= 1'b1;
                        chip_select_n <= 1'b1;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= S_WR_REC;
                    end
                end
                // recovery stretched to fill the cycle time
                S_WR_REC: begin
                    if (cnt_q >= WREC_CYC - 1'b1) begin
                        mem_dq_oe_n <= 1'b1;
                        lower_byte_enable_n <= 1'b1;
                        upper_byte_enable_n <= 1'b1;
                        rsp_valid <= 1'b1;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= S_GAP;
                    end
                end
                // select-high gap before the next access or standby
                S_GAP: begin
                    if (cnt_q >= CP_CYC - 1'b1 && cnt_q >= CHOX_CYC - 1'b1) begin
                        state_q <= S_IDLE;
                    end
                end
                // select high before program strobe, key set up
                S_PG_SET: begin
                    if (cnt_q >= EPS_CYC - 1'b1) begin
                        power_program_strobe_n <= 1'b0;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= S_PG_PULSE;
                    end
                end
                // program strobe low, key stable well beyond setup
                S_PG_PULSE: begin
                    if (cnt_q >= EP_CYC - 1'b1 && cnt_q >= EAS_CYC - 1'b1) begin
                        power_program_strobe_n <= 1'b1;
                        pgm_used_q <= 1'b1;
                        pd_mode <= pgm_mode;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= S_PG_HOLD;
                    end
                end
                // select stays high after the strobe rises
                S_PG_HOLD: begin
                    if (cnt_q >= EPH_CYC - 1'b1) begin
                        state_q <= S_IDLE;
                    end
                end
                // control low for the least entry hold
                S_PD_LOW: begin
                    if (cnt_q >= C2LP_CYC - 1'b1) begin
                        pd_active <= 1'b1;
                        state_q <= S_PD_ON;
                    end
                end
                // stay down until exit asked, then wait per mode
                S_PD_ON: begin
                    cnt_q <= {CNT_W{1'b0}};
                    if (pd_exit) begin
                        power_down_ctrl <= 1'b1;
                        init_done <= 1'b0;
                        // the hold reuses the start-up wait: sleep runs it in
                        // full, other modes start it part way so only the
                        // short hold remains before the gap
                        if (pd_mode == `PSAC_MODE_SLEEP) begin
                            cnt_q <= {CNT_W{1'b0}};
                        end else begin
                            cnt_q <= SLEEP_EXIT_CYC - OTHER_EXIT_CYC;
                        end
                        state_q <= S_PU_HOLD;
                    end
                end
                default: begin
                    state_q <= S_PU_LOW;
                end
            endcase
        end
    end

endmodule // psac_host

`default_nettype wire

// ---- tb/psac_host_chk.sv ----
/*
 checker for the strobe timing of the ram host port.
 assumes it is bound onto psac_host and that the clock period is 25 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module psac_host_chk (
    input wire clk,
    input wire rst,
    input wire chip_select_n,
    input wire output_enable_n,
    input wire write_enable_n,
    input wire lower_byte_enable_n,
    input wire upper_byte_enable_n,
    input wire power_down_ctrl,
    input wire power_program_strobe_n,
    input wire init_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // read strobes and byte lanes
    a_read_quiet: assert property (!chip_select_n && !output_enable_n |->
        power_down_ctrl && power_program_strobe_n && write_enable_n) else $error("read strobes");
    a_lane_on: assert property (!chip_select_n && !output_enable_n |->
        !(lower_byte_enable_n && upper_byte_enable_n)) else $error("no byte lane");
    a_read_cycle: assert property ($fell(output_enable_n) |-> !chip_select_n [*3])
        else $error("read cycle short");
    a_no_read_first: assert property ($fell(chip_select_n) && !write_enable_n |->
        output_enable_n) else $error("read started before write");
    // write strobes
    a_write_ctrl: assert property (!write_enable_n |->
        power_down_ctrl && power_program_strobe_n) else $error("write controls");
    a_write_pulse: assert property ($fell(write_enable_n) |->
        (!write_enable_n && !chip_select_n) [*2]) else $error("write pulse short");
    a_write_cycle: assert property ($fell(write_enable_n) |=>
        !$fell(write_enable_n) [*2]) else $error("write cycle short");
    a_select_gap: assert property ($rose(chip_select_n) |=>
        chip_select_n && write_enable_n && output_enable_n) else $error("select gap");
    // power down, program and start-up
    a_pd_entry: assert property ($fell(power_down_ctrl) |->
        (!power_down_ctrl && chip_select_n) [*3]) else $error("power down entry short");
    a_pgm_pulse: assert property ($fell(power_program_strobe_n) |->
        (!power_program_strobe_n && power_down_ctrl && chip_select_n) [*3])
        else $error("program pulse");
    a_exit_hold: assert property ($rose(power_down_ctrl) |-> chip_select_n [*2])
        else $error("exit hold short");
    a_blocked: assert property (!init_done |-> chip_select_n)
        else $error("access before init");
endmodule // psac_host_chk
`default_nettype wire

// ---- tb/psac_mem_model.sv ----
/*
 behavioural model of the pseudo-static ram die, 16 words deep.
 assumes the host drives all strobes; reads answer after 65 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module psac_mem_model (
    input wire [21:0] mem_addr,
    input wire [15:0] mem_dq_out,
    input wire mem_dq_oe_n,
    input wire chip_select_n,
    input wire output_enable_n,
    input wire write_enable_n,
    input wire lower_byte_enable_n,
    input wire upper_byte_enable_n,
    input wire power_down_ctrl,
    input wire power_program_strobe_n,
    output wire [15:0] mem_dq_in,
    output logic [1:0] key_mode,
    output logic key_top
);
    logic [15:0] mem [0:15];
    logic [15:0] last_q;
    wire rd_on = !chip_select_n && !output_enable_n && write_enable_n && power_down_ctrl;
    wire [15:0] cur = mem[mem_addr[3:0]];

    // start state: sleep key, blank words
    initial begin
        key_mode = 2'h3;
        key_top = 1'b0;
        last_q = 16'h5A5A;
        for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    end
    // write while select and strobe are both low
    always @* begin
        if (!chip_select_n && !write_enable_n && !mem_dq_oe_n && power_down_ctrl) begin
            if (!lower_byte_enable_n) mem[mem_addr[3:0]][7:0] = mem_dq_out[7:0];
            if (!upper_byte_enable_n) mem[mem_addr[3:0]][15:8] = mem_dq_out[15:8];
        end
        if (rd_on) last_q = cur;
    end
    // released bus shows inverse of last value
    assign #65 mem_dq_in = rd_on ? cur : ~last_q;
    // program key latched as strobe rises
    always @(posedge power_program_strobe_n) begin
        if (power_down_ctrl && chip_select_n) begin
            key_mode = {mem_addr[17], mem_addr[16]};
            key_top = mem_addr[21];
        end
    end
    // entry loses all but a kept bottom half
    always @(negedge power_down_ctrl) begin
        if (chip_select_n && !(key_mode == 2'h1 && !key_top)) begin
            for (int i = 0; i < 16; i++) mem[i] = ~mem[i];
        end
    end
endmodule // psac_mem_model
`default_nettype wire

// ---- tb/psac_host_tb_top.sv ----
/*
 testbench for psac_host with the ram model on its pins.
 assumes shortened start-up and exit counts of 4, 8 and 2 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module psac_host_tb_top;
    logic clk, rst, req_valid, req_write, pd_enter, pd_exit, pgm_req, pgm_top;
    logic [21:0] req_addr;
    logic [15:0] req_wdata, q;
    logic [1:0] req_be, pgm_mode;
    wire req_ready, rsp_valid, pd_active, init_done, mem_dq_oe_n, key_top;
    wire chip_select_n, output_enable_n, write_enable_n, lower_byte_enable_n;
    wire upper_byte_enable_n, power_down_ctrl, power_program_strobe_n;
    wire [15:0] rsp_rdata, mem_dq_in, mem_dq_out;
    wire [21:0] mem_addr;
    wire [1:0] pd_mode, key_mode;
    int bad_count, checks;

    psac_host #(.PWRUP_LOW_CYC(24'h4), .SLEEP_EXIT_CYC(24'h8), .OTHER_EXIT_CYC(24'h2)) u_dut (.*);
    psac_mem_model u_mem (.*);

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one request, timed from ready to response
    task automatic access(input logic wr, input logic [21:0] a, input logic [15:0] d,
        input logic [1:0] be);
        int n;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        req_be <= be;
        n = 0;
        do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 60);
        req_valid <= 1'b0;
        n = 0;
        do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 60);
        check("latency", wr ? 16'h3 : 16'h6, 16'(n));
        q = rsp_rdata;
        @(posedge clk);
    endtask
    task automatic t_powerup;
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 200) begin @(posedge clk); n++; end
        check("init wait", 16'h1, 16'(n >= 12));
        check("default mode", 16'h3, {14'h0, pd_mode});
    endtask
    task automatic t_program;
        int n;
        pgm_mode <= 2'h1;
        pgm_top <= 1'b0;
        pgm_req <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (key_mode !== 2'h1 && n < 40);
        pgm_req <= 1'b0;
        check("key mode", 16'h1, {14'h0, key_mode});
        check("key half", 16'h0, {15'h0, key_top});
        check("programmed mode", 16'h1, {14'h0, pd_mode});
    endtask
    task automatic t_bytes;
        req_valid <= 1'b1;
        req_be <= 2'h0;
        repeat (10) @(posedge clk);
        check("empty lanes taken", 16'h0, {15'h0, req_ready});
        access(1'b1, 22'h3, 16'h1234, 2'h3);
        access(1'b1, 22'h5, 16'hA55A, 2'h3);
        access(1'b1, 22'h3, 16'hFFAB, 2'h1);
        access(1'b1, 22'h3, 16'hCDFF, 2'h2);
        access(1'b0, 22'h3, 16'h0000, 2'h3);
        check("merged word", 16'hCDAB, q);
        access(1'b0, 22'h5, 16'h0000, 2'h3);
        check("second word", 16'hA55A, q);
    endtask
    task automatic t_powerdown;
        int n;
        pd_enter <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pd_active !== 1'b1 && n < 40);
        check("down pins", 16'h1, {15'h0, chip_select_n & ~power_down_ctrl});
        pd_enter <= 1'b0;
        pd_exit <= 1'b1;
        @(posedge clk);
        n = 0;
        do begin @(posedge clk); n++; end while (init_done !== 1'b1 && n < 100);
        pd_exit <= 1'b0;
        check("exit wait", 16'h3, 16'(n));
        check("down flag after exit", 16'h0, {15'h0, pd_active});
        access(1'b0, 22'h3, 16'h0000, 2'h3);
        check("kept half", 16'hCDAB, q);
    endtask
    task automatic t_reprogram;
        pgm_mode <= 2'h0;
        pgm_req <= 1'b1;
        repeat (20) @(posedge clk);
        pgm_req <= 1'b0;
        check("late key", 16'h1, {14'h0, key_mode});
    endtask

    // clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // watchdog
    initial begin
        #(25 * 5000);
        bad_count++;
        finish_test;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        {req_valid, req_write, pd_enter, pd_exit, pgm_req, pgm_top} = 6'h00;
        req_addr = 22'h0;
        req_wdata = 16'h0;
        req_be = 2'h0;
        pgm_mode = 2'h3;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_powerup;
        t_program;
        t_bytes;
        t_powerdown;
        t_reprogram;
        finish_test;
    end
endmodule // psac_host_tb_top

bind psac_host psac_host_chk u_chk (.*);
`default_nettype wire
